/* pkg/bbss_map.svh */
// Constants of the buck-boost switch sequencer: offsets, fields, timing.
// Assumes a 25 MHz system clock; included by the sync monitor, the sequencer and the bench top.
`ifndef BBSS_MAP_SVH
`define BBSS_MAP_SVH

// Clock
`define BBSS_CLK_KHZ 25000
`define BBSS_CLK_PER_NS 40

// Register offsets (byte addresses)
`define BBSS_ADDR_CTRL 4'h0
`define BBSS_ADDR_STATUS 4'h4

// Control fields
`define BBSS_CTRL_RUN 0
`define BBSS_CTRL_FSW_LO 1
`define BBSS_CTRL_FSW_HI 2
`define BBSS_CTRL_DITHER_EN 3
`define BBSS_CTRL_DITHER_RATE 4
`define BBSS_CTRL_SYNC_IN 5
`define BBSS_CTRL_PHASE_LO 6
`define BBSS_CTRL_PHASE_HI 7
`define BBSS_CTRL_RESET 8'h00

// Status fields
`define BBSS_STAT_REGION_LO 0
`define BBSS_STAT_REGION_HI 1
`define BBSS_STAT_LOCKED 2
`define BBSS_STAT_RUNNING 3
`define BBSS_STAT_OVP 4
`define BBSS_STAT_UV 5

// Switching frequencies and oscillator periods in cycles
`define BBSS_FSW0_KHZ 300
`define BBSS_FSW1_KHZ 400
`define BBSS_FSW2_KHZ 450
`define BBSS_PER0 (`BBSS_CLK_KHZ / `BBSS_FSW0_KHZ)
`define BBSS_PER1 (`BBSS_CLK_KHZ / `BBSS_FSW1_KHZ)
`define BBSS_PER2 (`BBSS_CLK_KHZ / `BBSS_FSW2_KHZ)

// Dither span in percent and modulation rates
`define BBSS_DITHER_PCT 10
`define BBSS_SPAN0 (`BBSS_PER0 * `BBSS_DITHER_PCT / 100)
`define BBSS_SPAN1 (`BBSS_PER1 * `BBSS_DITHER_PCT / 100)
`define BBSS_SPAN2 (`BBSS_PER2 * `BBSS_DITHER_PCT / 100)
`define BBSS_MOD0_KHZ 10
`define BBSS_MOD1_KHZ 25
`define BBSS_MOD0 (`BBSS_CLK_KHZ / `BBSS_MOD0_KHZ)
`define BBSS_MOD1 (`BBSS_CLK_KHZ / `BBSS_MOD1_KHZ)

// External sync windows in kHz, converted to period limits in cycles
`define BBSS_SYNC0_MIN_KHZ 250
`define BBSS_SYNC0_MAX_KHZ 353
`define BBSS_SYNC1_MIN_KHZ 334
`define BBSS_SYNC1_MAX_KHZ 470
`define BBSS_SYNC2_MIN_KHZ 376
`define BBSS_SYNC2_MAX_KHZ 530
`define BBSS_CEILDIV(a, b) (((a) + (b) - 1) / (b))
`define BBSS_SPMIN0 `BBSS_CEILDIV(`BBSS_CLK_KHZ, `BBSS_SYNC0_MAX_KHZ)
`define BBSS_SPMAX0 (`BBSS_CLK_KHZ / `BBSS_SYNC0_MIN_KHZ)
`define BBSS_SPMIN1 `BBSS_CEILDIV(`BBSS_CLK_KHZ, `BBSS_SYNC1_MAX_KHZ)
`define BBSS_SPMAX1 (`BBSS_CLK_KHZ / `BBSS_SYNC1_MIN_KHZ)
`define BBSS_SPMIN2 `BBSS_CEILDIV(`BBSS_CLK_KHZ, `BBSS_SYNC2_MAX_KHZ)
`define BBSS_SPMAX2 (`BBSS_CLK_KHZ / `BBSS_SYNC2_MIN_KHZ)
`define BBSS_SYNC_GOOD 4'h8

// Fixed times of the transition regions and dead interval
`define BBSS_TOFF_NS 400
`define BBSS_TON_NS 400
`define BBSS_DEAD_NS 80
`define BBSS_TOFF `BBSS_CEILDIV(`BBSS_TOFF_NS, `BBSS_CLK_PER_NS)
`define BBSS_TON `BBSS_CEILDIV(`BBSS_TON_NS, `BBSS_CLK_PER_NS)
`define BBSS_DEAD `BBSS_CEILDIV(`BBSS_DEAD_NS, `BBSS_CLK_PER_NS)

// Region ratio k = 6/5
`define BBSS_K_NUM 6
`define BBSS_K_DEN 5

`endif

/* pkg/bbss_pkg.sv */
// Types of the buck-boost switch sequencer.
// Assumes nothing beyond the constants header.
package bbss_pkg;
    typedef enum logic [1:0] {
        BBSS_BUCK = 2'b00,
        BBSS_BUCK_TR = 2'b01,
        BBSS_BOOST_TR = 2'b10,
        BBSS_BOOST = 2'b11
    } bbss_region_type;

    typedef enum logic [1:0] {
        BBSS_ST_STOP = 2'b00,
        BBSS_ST_FIRST = 2'b01,
        BBSS_ST_SECOND = 2'b10
    } bbss_state_type;
endpackage

/* hdl/bbss_sync_monitor.sv */
// External sync clock qualifier: edge detect, period check, lock count.
// Assumes the sync pin is asynchronous to clk; limits come from the top.
`timescale 1ns/1ps
`default_nettype none
`include "bbss_map.svh"
module bbss_sync_monitor
    import bbss_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic sync_pin,
    input wire logic [7:0] min_per,
    input wire logic [7:0] max_per,
    output logic edge_pulse,
    output logic locked
);
    logic sync_ff1;
    logic sync_ff2;
    logic sync_prev;
    logic [7:0] per_cnt;
    logic [3:0] good_cnt;
    wire rise;
    wire [7:0] period;
    wire in_range;
    wire timeout;

    // Two-stage synchroniser for the pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ff1 <= 1'b0;
            sync_ff2 <= 1'b0;
        end else begin
            sync_ff1 <= sync_pin;
            sync_ff2 <= sync_ff1;
        end
    end

    // Period of the edge just seen and window check
    assign rise = enable & sync_ff2 & ~sync_prev;
    assign period = per_cnt + 8'h01;
    assign in_range = (period >= min_per) && (period <= max_per);
    assign timeout = per_cnt >= max_per;
    assign edge_pulse = rise & locked;

    // Period counter and consecutive good count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev <= 1'b0;
            per_cnt <= 8'h00;
            good_cnt <= 4'h0;
            locked <= 1'b0;
        end else if (!enable) begin
            sync_prev <= 1'b0;
            per_cnt <= 8'h00;
            good_cnt <= 4'h0;
            locked <= 1'b0;
        end else begin
            sync_prev <= sync_ff2;
            if (rise) begin
                per_cnt <= 8'h00;
                if (in_range) begin
                    if (good_cnt != `BBSS_SYNC_GOOD) begin
                        good_cnt <= good_cnt + 4'h1;
                    end
                    if (good_cnt == `BBSS_SYNC_GOOD - 4'h1) begin
                        locked <= 1'b1;
                    end
                end else begin
                    good_cnt <= 4'h0;
                    locked <= 1'b0;
                end
            end else if (timeout) begin
                good_cnt <= 4'h0;
                locked <= 1'b0;
            end else begin
                per_cnt <= per_cnt + 8'h01;
            end
        end
    end
endmodule // bbss_sync_monitor
`default_nettype wire

/* hdl/bbss_sequencer.sv */
// Buck-boost switch sequencer: region choice, five switch drives,
// oscillator with dither, sync pin in or out, register port.
// Assumes comparator and fault pins are asynchronous; voltage codes are
// from same-clock converter logic; the sync pin is two-way.
`timescale 1ns/1ps
`default_nettype none
`include "bbss_map.svh"
module bbss_sequencer
    import bbss_pkg::*;
(
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic [11:0] VIN_CODE,
    input wire logic [11:0] VOUT_CODE,
    input wire logic PEAK_TRIP,
    input wire logic VALLEY_TRIP,
    input wire logic INPUT_OVERVOLTAGE,
    input wire logic UNDERVOLTAGE_LOCKOUT,
    input wire logic ENABLE_UNDERVOLTAGE_PIN,
    output logic BUCK_HIGH_SWITCH,
    output logic BUCK_LOW_SWITCH,
    output logic BOOST_HIGH_SWITCH,
    output logic BOOST_LOW_SWITCH,
    output logic REVERSE_BLOCK_SWITCH,
    input wire logic SYNC_IN,
    output logic SYNC_OUT,
    output logic SYNC_OE_N
);
    logic [1:0] rst_ff;
    logic rst_n;
    logic [7:0] ctrl;
    logic [2:0] pin_ff1;
    logic [2:0] pin_ff2;
    logic [1:0] trip_ff1;
    logic [1:0] trip_ff2;
    logic [7:0] osc_cnt;
    logic [7:0] step_cnt;
    logic signed [4:0] dith_off;
    logic dith_up;
    logic had_lock;
    bbss_state_type state;
    bbss_state_type next_state;
    bbss_region_type region;
    logic boost_cycle;
    logic [4:0] tcnt;
    logic sync_wave;
    logic reg_m5;

    // Reset release through two flip-flops
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_ff <= 2'b00;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_ff[1];

    // Two-flop synchronisers for faults and comparators
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_ff1 <= 3'h0;
            pin_ff2 <= 3'h0;
            trip_ff1 <= 2'h0;
            trip_ff2 <= 2'h0;
        end else begin
            pin_ff1 <= {INPUT_OVERVOLTAGE, UNDERVOLTAGE_LOCKOUT,
                        ENABLE_UNDERVOLTAGE_PIN};
            pin_ff2 <= pin_ff1;
            trip_ff1 <= {PEAK_TRIP, VALLEY_TRIP};
            trip_ff2 <= trip_ff1;
        end
    end

    // Control fields and fault decode
    wire run_en = ctrl[`BBSS_CTRL_RUN];
    wire [1:0] fsw_sel = ctrl[`BBSS_CTRL_FSW_HI:`BBSS_CTRL_FSW_LO];
    wire dither_en = ctrl[`BBSS_CTRL_DITHER_EN];
    wire dither_rate = ctrl[`BBSS_CTRL_DITHER_RATE];
    wire sync_in_mode = ctrl[`BBSS_CTRL_SYNC_IN];
    wire [1:0] phase_sel = ctrl[`BBSS_CTRL_PHASE_HI:`BBSS_CTRL_PHASE_LO];
    wire input_overvoltage_indication = pin_ff2[2];
    wire uv = pin_ff2[1] | pin_ff2[0];
    wire peak = trip_ff2[1];
    wire valley = trip_ff2[0];
    wire run_ok = run_en & ~input_overvoltage_indication & ~uv;

    // Base period, dither span and sync window per frequency
    logic [7:0] base_per;
    logic [4:0] span;
    logic [7:0] sp_min;
    logic [7:0] sp_max;
    logic [7:0] step_int;
    always_comb begin
        case (fsw_sel)
            2'b01: begin
                base_per = 8'(`BBSS_PER1);
                span = 5'(`BBSS_SPAN1);
                sp_min = 8'(`BBSS_SPMIN1);
                sp_max = 8'(`BBSS_SPMAX1);
            end
            2'b10: begin
                base_per = 8'(`BBSS_PER2);
                span = 5'(`BBSS_SPAN2);
                sp_min = 8'(`BBSS_SPMIN2);
                sp_max = 8'(`BBSS_SPMAX2);
            end
            default: begin
                base_per = 8'(`BBSS_PER0);
                span = 5'(`BBSS_SPAN0);
                sp_min = 8'(`BBSS_SPMIN0);
                sp_max = 8'(`BBSS_SPMAX0);
            end
        endcase
        case ({fsw_sel, dither_rate})
            3'b010: step_int = 8'(`BBSS_MOD0 / (4 * `BBSS_SPAN1));
            3'b011: step_int = 8'(`BBSS_MOD1 / (4 * `BBSS_SPAN1));
            3'b100: step_int = 8'(`BBSS_MOD0 / (4 * `BBSS_SPAN2));
            3'b101: step_int = 8'(`BBSS_MOD1 / (4 * `BBSS_SPAN2));
            3'b001: step_int = 8'(`BBSS_MOD1 / (4 * `BBSS_SPAN0));
            3'b111: step_int = 8'(`BBSS_MOD1 / (4 * `BBSS_SPAN0));
            default: step_int = 8'(`BBSS_MOD0 / (4 * `BBSS_SPAN0));
        endcase
    end

    // External sync qualifier
    logic ext_edge;
    logic ext_locked;
    bbss_sync_monitor u_sync_monitor (
        .clk(MCLK),
        .rst_n(rst_n),
        .enable(sync_in_mode),
        .sync_pin(SYNC_IN),
        .min_per(sp_min),
        .max_per(sp_max),
        .edge_pulse(ext_edge),
        .locked(ext_locked)
    );

    // Dither allowed unless running internally after a sync failure
    wire dith_act = dither_en
                    & ~(sync_in_mode & had_lock & ~ext_locked);
    wire signed [8:0] per_sum = $signed({1'b0, base_per})
                                + 9'(dith_off);
    wire [7:0] cur_per = per_sum[7:0];
    wire osc_wrap = (osc_cnt >= cur_per - 8'h01);
    wire cycle_start = ext_locked ? ext_edge : osc_wrap;

    // Oscillator counter, restarted by the external edge when locked
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt <= 8'h00;
            had_lock <= 1'b0;
        end else begin
            if (cycle_start) begin
                osc_cnt <= 8'h00;
            end else if (osc_cnt != 8'hff) begin
                osc_cnt <= osc_cnt + 8'h01;
            end
            if (!sync_in_mode) begin
                had_lock <= 1'b0;
            end else if (ext_locked) begin
                had_lock <= 1'b1;
            end
        end
    end

    // Triangular dither of the period, stepped once per step interval
    wire [4:0] off_mag = dith_off[4] ? 5'(-dith_off) : dith_off[4:0];
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt <= 8'h00;
            dith_off <= 5'sd0;
            dith_up <= 1'b1;
        end else if (!dith_act) begin
            step_cnt <= 8'h00;
            dith_off <= 5'sd0;
            dith_up <= 1'b1;
        end else if (step_cnt >= step_int - 8'h01) begin
            step_cnt <= 8'h00;
            if (dith_up) begin
                dith_off <= dith_off + 5'sd1;
                dith_up <= !(!dith_off[4] && off_mag == span - 5'h01);
            end else begin
                dith_off <= dith_off - 5'sd1;
                dith_up <= dith_off[4] && off_mag == span - 5'h01;
            end
        end else begin
            step_cnt <= step_cnt + 8'h01;
        end
    end

    // Sync output: half-period high, shifted by the selected phase
    logic [7:0] shift;
    always_comb begin
        case (phase_sel)
            2'b01: shift = cur_per >> 2;
            2'b10: shift = 8'(cur_per / 8'd3);
            2'b11: shift = cur_per >> 1;
            default: shift = 8'h00;
        endcase
    end
    wire [7:0] shifted = (osc_cnt >= shift) ? osc_cnt - shift
                                            : osc_cnt + cur_per - shift;
    wire next_sync_wave = shifted < (cur_per >> 1);
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            sync_wave <= 1'b0;
        end else begin
            sync_wave <= next_sync_wave;
        end
    end
    assign SYNC_OUT = sync_wave & ~sync_in_mode;
    assign SYNC_OE_N = sync_in_mode;

    // Region from output against input scaled by k = 6/5
    wire [14:0] vout_den = 15'(VOUT_CODE) * 15'(`BBSS_K_DEN);
    wire [14:0] vin_num = 15'(VIN_CODE) * 15'(`BBSS_K_NUM);
    wire [14:0] vout_num = 15'(VOUT_CODE) * 15'(`BBSS_K_NUM);
    wire [14:0] vin_den = 15'(VIN_CODE) * 15'(`BBSS_K_DEN);
    bbss_region_type next_region;
    assign next_region = (vout_den > vin_num) ? BBSS_BOOST
        : (VOUT_CODE > VIN_CODE) ? BBSS_BOOST_TR
        : (vout_num > vin_den) ? BBSS_BUCK_TR
        : BBSS_BUCK;

    // Cycle kind: fixed in pure regions, alternating in transition regions
    wire transition = (next_region == BBSS_BOOST_TR) ||
                      (next_region == BBSS_BUCK_TR);
    wire fresh = (state == BBSS_ST_STOP) || (next_region != region);
    wire primary_boost = next_region[1];
    wire next_boost_cycle = (transition && !fresh) ? ~boost_cycle
                                                   : primary_boost;

    // End of the first phase: comparator or fixed time
    wire fixed_boost = (region == BBSS_BUCK_TR);
    wire fixed_buck = (region == BBSS_BOOST_TR);
    wire first_done = boost_cycle
        ? (fixed_boost ? (tcnt >= 5'(`BBSS_TON) - 5'h01) : peak)
        : (fixed_buck ? (tcnt >= 5'(`BBSS_TOFF) - 5'h01) : valley);

    // Cycle state machine
    always_comb begin
        case (state)
            BBSS_ST_STOP: next_state = (run_ok && cycle_start)
                                       ? BBSS_ST_FIRST : BBSS_ST_STOP;
            BBSS_ST_FIRST: next_state = first_done ? BBSS_ST_SECOND
                                                   : BBSS_ST_FIRST;
            BBSS_ST_SECOND: next_state = BBSS_ST_SECOND;
            default: next_state = BBSS_ST_STOP;
        endcase
        if (!run_ok) begin
            next_state = BBSS_ST_STOP;
        end else if (cycle_start) begin
            next_state = BBSS_ST_FIRST;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= BBSS_ST_STOP;
            region <= BBSS_BOOST;
            boost_cycle <= 1'b1;
            tcnt <= 5'h00;
        end else begin
            state <= next_state;
            if (run_ok && cycle_start) begin
                region <= next_region;
                boost_cycle <= next_boost_cycle;
                tcnt <= 5'h00;
            end else if (tcnt != 5'h1f) begin
                tcnt <= tcnt + 5'h01;
            end
        end
    end

    // Wanted switch pattern: boost cycle keeps buck high on, buck cycle
    // keeps boost high on; first phase uses the low switch
    wire running = (state != BBSS_ST_STOP);
    wire first = (state == BBSS_ST_FIRST);
    logic [1:0] want_hl [2];
    always_comb begin
        want_hl[0] = 2'b00;
        want_hl[1] = 2'b00;
        if (running && boost_cycle) begin
            want_hl[0] = 2'b10;
            want_hl[1] = first ? 2'b01 : 2'b10;
        end else if (running) begin
            want_hl[0] = first ? 2'b01 : 2'b10;
            want_hl[1] = 2'b10;
        end
    end

    // Dead-time gate per half-bridge: both off, wait, then apply
    logic [1:0] drv_hl [2];
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_bridge
            logic [1:0] drv;
            logic [3:0] dcnt;
            always_ff @(posedge MCLK or negedge rst_n) begin
                if (!rst_n) begin
                    drv <= 2'b00;
                    dcnt <= 4'h0;
                end else if (drv != want_hl[gi]) begin
                    if (drv != 2'b00) begin
                        drv <= 2'b00;
                        dcnt <= 4'(`BBSS_DEAD);
                    end else if (dcnt != 4'h0) begin
                        dcnt <= dcnt - 4'h1;
                    end else begin
                        drv <= want_hl[gi];
                    end
                end else if (dcnt != 4'h0) begin
                    dcnt <= dcnt - 4'h1;
                end
            end
            assign drv_hl[gi] = drv;
        end
    endgenerate

    // Blocking switch closed whenever the stage runs
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            reg_m5 <= 1'b0;
        end else begin
            reg_m5 <= running;
        end
    end
    assign BUCK_HIGH_SWITCH = drv_hl[0][1];
    assign BUCK_LOW_SWITCH = drv_hl[0][0];
    assign BOOST_HIGH_SWITCH = drv_hl[1][1];
    assign BOOST_LOW_SWITCH = drv_hl[1][0];
    assign REVERSE_BLOCK_SWITCH = reg_m5;

    // Register decode
    wire sel_ctrl = (ADDR == `BBSS_ADDR_CTRL);
    wire sel_stat = (ADDR == `BBSS_ADDR_STATUS);
    logic [31:0] status;
    always_comb begin
        status = 32'h0;
        status[`BBSS_STAT_REGION_HI:`BBSS_STAT_REGION_LO] = region;
        status[`BBSS_STAT_LOCKED] = ext_locked;
        status[`BBSS_STAT_RUNNING] = running;
        status[`BBSS_STAT_OVP] = input_overvoltage_indication;
        status[`BBSS_STAT_UV] = uv;
    end
    wire [31:0] rd_mux = sel_ctrl ? {24'h0, ctrl}
                       : sel_stat ? status : 32'h0;

    // Register write and one-cycle-late read data
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `BBSS_CTRL_RESET;
            RDATA <= 32'h0;
        end else begin
            if (WR && sel_ctrl) begin
                ctrl <= WDATA[7:0];
            end
            if (RD) begin
                RDATA <= rd_mux;
            end
        end
    end
endmodule // bbss_sequencer
`default_nettype wire

/* verif/bbss_power_stage.sv */
// Power stage stand-in: comparators and external sync clock.
// Assumes switch drives high mean closed; ext_per 0 stops the clock.
`timescale 1ns/1ps
`default_nettype none
module bbss_power_stage #(
    parameter int RAMP = 20
) (
    input wire logic clk,
    input wire logic boost_low,
    input wire logic buck_low,
    input wire logic [7:0] ext_per,
    output logic peak_trip,
    output logic valley_trip,
    output logic sync_pin
);
    int bo_cnt = 0;
    int bu_cnt = 0;
    int s_cnt = 0;
    // Inductor current ramps while a low switch conducts
    always @(posedge clk) begin
        bo_cnt <= boost_low ? bo_cnt + 1 : 0;
        bu_cnt <= buck_low ? bu_cnt + 1 : 0;
        s_cnt <= (s_cnt + 1 >= int'(ext_per)) ? 0 : s_cnt + 1;
    end
    // Comparators trip after the ramp time
    assign peak_trip = boost_low && bo_cnt >= RAMP;
    assign valley_trip = buck_low && bu_cnt >= RAMP;
    // External clock, held low when stopped
    assign sync_pin = ext_per != 8'h00 && s_cnt < int'(ext_per) / 2;
endmodule // bbss_power_stage
`default_nettype wire

/* verif/bbss_sequencer_chk.sv */
// Checker of bridge safety, fault stops and sync pin mode.
// Bound to the sequencer top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module bbss_sequencer_chk (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic INPUT_OVERVOLTAGE,
    input wire logic UNDERVOLTAGE_LOCKOUT,
    input wire logic ENABLE_UNDERVOLTAGE_PIN,
    input wire logic BUCK_HIGH_SWITCH,
    input wire logic BUCK_LOW_SWITCH,
    input wire logic BOOST_HIGH_SWITCH,
    input wire logic BOOST_LOW_SWITCH,
    input wire logic REVERSE_BLOCK_SWITCH,
    input wire logic SYNC_OUT,
    input wire logic SYNC_OE_N
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // Faults held past synchroniser and stop latency
    sequence s_ovp;
        INPUT_OVERVOLTAGE [*7];
    endsequence
    sequence s_uv;
        (UNDERVOLTAGE_LOCKOUT || ENABLE_UNDERVOLTAGE_PIN) [*7];
    endsequence
    // Any switch closed
    wire any_on = BUCK_HIGH_SWITCH || BUCK_LOW_SWITCH || BOOST_HIGH_SWITCH ||
                  BOOST_LOW_SWITCH || REVERSE_BLOCK_SWITCH;
    AST_BUCK_BRIDGE: assert property (
        !(BUCK_HIGH_SWITCH && BUCK_LOW_SWITCH))
        else $error("buck half-bridge shorted");
    AST_BOOST_BRIDGE: assert property (
        !(BOOST_HIGH_SWITCH && BOOST_LOW_SWITCH))
        else $error("boost half-bridge shorted");
    AST_BUCK_DEAD: assert property (
        $fell(BUCK_LOW_SWITCH) |-> !BUCK_HIGH_SWITCH [*3])
        else $error("buck dead interval too short");
    AST_BOOST_DEAD: assert property (
        $fell(BOOST_LOW_SWITCH) |-> !BOOST_HIGH_SWITCH [*3])
        else $error("boost dead interval too short");
    AST_OVP_STOP: assert property (s_ovp |-> !any_on)
        else $error("switching during overvoltage");
    AST_UV_STOP: assert property (s_uv |-> !any_on)
        else $error("switching during undervoltage");
    AST_BOOST_CTX: assert property (
        BOOST_LOW_SWITCH |-> REVERSE_BLOCK_SWITCH && !BUCK_LOW_SWITCH)
        else $error("boost on-time with wrong buck half");
    AST_SYNC_QUIET: assert property (SYNC_OE_N |-> !SYNC_OUT)
        else $error("sync output active in input mode");
endmodule // bbss_sequencer_chk
bind bbss_sequencer bbss_sequencer_chk i_bbss_sequencer_chk (.MCLK(MCLK),
    .RSTN(RSTN), .INPUT_OVERVOLTAGE(INPUT_OVERVOLTAGE),
    .UNDERVOLTAGE_LOCKOUT(UNDERVOLTAGE_LOCKOUT),
    .ENABLE_UNDERVOLTAGE_PIN(ENABLE_UNDERVOLTAGE_PIN),
    .BUCK_HIGH_SWITCH(BUCK_HIGH_SWITCH), .BUCK_LOW_SWITCH(BUCK_LOW_SWITCH),
    .BOOST_HIGH_SWITCH(BOOST_HIGH_SWITCH), .BOOST_LOW_SWITCH(BOOST_LOW_SWITCH),
    .REVERSE_BLOCK_SWITCH(REVERSE_BLOCK_SWITCH), .SYNC_OUT(SYNC_OUT),
    .SYNC_OE_N(SYNC_OE_N));
`default_nettype wire

/* verif/bbss_sequencer_tb_top.sv */
// Self-checking bench of the switch sequencer.
// Uses the power stage model; the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
`include "bbss_map.svh"
module bbss_sequencer_tb_top
    import bbss_pkg::*;
;
    typedef struct {logic [7:0] ctrl; logic [11:0] vout; int per;
        bbss_region_type rgn;} bbss_row_type;
    logic mclk = 0, rst_n = 0, wr = 0, rd = 0, input_overvoltage_indication = 0, uvl = 0, enuv = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, st;
    logic [11:0] vin = 12'h3e8, vout = 12'h3e8;
    logic peak, valley, ext_pin, sync_in, sync_out, sync_oe_n;
    logic bkh, bkl, boh, bol, rbs;
    logic [7:0] ext_per = 8'h00;
    int miscompares = 0, checks_done = 0, hi, tot, on, bad;
    bbss_row_type rows [6] = '{'{8'h01, 12'h4b1, `BBSS_PER0, BBSS_BOOST},
        '{8'h03, 12'h4b0, `BBSS_PER1, BBSS_BOOST_TR},
        '{8'h05, 12'h3e9, `BBSS_PER2, BBSS_BOOST_TR},
        '{8'h47, 12'h3e8, `BBSS_PER0, BBSS_BUCK_TR},
        '{8'hc3, 12'h342, `BBSS_PER1, BBSS_BUCK_TR},
        '{8'h81, 12'h341, `BBSS_PER0, BBSS_BUCK}};
    // Clock
    initial forever #20 mclk = ~mclk;
    // Sync wire resolved from both drivers
    assign sync_in = sync_oe_n ? ext_pin : sync_out;
    bbss_sequencer i_bbss_sequencer (.MCLK(mclk), .RSTN(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .VIN_CODE(vin),
        .VOUT_CODE(vout), .PEAK_TRIP(peak), .VALLEY_TRIP(valley),
        .INPUT_OVERVOLTAGE(input_overvoltage_indication), .UNDERVOLTAGE_LOCKOUT(uvl),
        .ENABLE_UNDERVOLTAGE_PIN(enuv), .BUCK_HIGH_SWITCH(bkh),
        .BUCK_LOW_SWITCH(bkl), .BOOST_HIGH_SWITCH(boh), .BOOST_LOW_SWITCH(bol),
        .REVERSE_BLOCK_SWITCH(rbs), .SYNC_IN(sync_in), .SYNC_OUT(sync_out),
        .SYNC_OE_N(sync_oe_n));
    bbss_power_stage i_bbss_power_stage (.clk(mclk), .boost_low(bol),
        .buck_low(bkl), .ext_per(ext_per), .peak_trip(peak),
        .valley_trip(valley), .sync_pin(ext_pin));
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        st = rdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One sync output period: high count and total
    task automatic meas;
        hi = 0;
        tot = 0;
        while (sync_out !== 1'b0) @(negedge mclk);
        while (sync_out !== 1'b1) @(negedge mclk);
        do begin
            hi += sync_out;
            tot++;
            @(negedge mclk);
        end while (!(sync_out && tot > hi));
    endtask
    task automatic summarize;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        summarize;
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        chk({bkh, bkl, boh, bol, rbs, sync_oe_n}, 32'h0);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        bus_rd(4'h0);
        chk(st, 32'h0);
        $display("reset done");
        foreach (rows[i]) begin
            bus_wr(4'h0, {24'h0, rows[i].ctrl});
            vout <= rows[i].vout;
            repeat (200) @(posedge mclk);
            meas;
            chk(tot, rows[i].per);
            chk(hi, rows[i].per / 2);
            bus_rd(4'h4);
            chk(st, 32'h8 | 32'(rows[i].rgn));
        end
        $display("rows done");
        // Dither stretches the period inside its span
        bus_wr(4'h0, 32'h19);
        repeat (1150) @(posedge mclk);
        meas;
        on = tot - `BBSS_PER0;
        chk(on inside {[1:`BBSS_SPAN0]}, 1);
        $display("dither done");
        // Boost transition: fixed buck off-time, boost high held
        bus_wr(4'h0, 32'h1);
        vout <= 12'h3e9;
        repeat (200) @(posedge mclk);
        on = 0;
        bad = 0;
        @(posedge bkl);
        while (bkl) begin
            @(negedge mclk);
            on++;
            bad += !(boh && rbs && !bol);
        end
        chk(on inside {[`BBSS_TOFF - 4:`BBSS_TOFF]}, 1);
        chk(bad, 0);
        repeat (4) @(negedge mclk);
        chk(bkh, 1);
        @(posedge bol);
        @(negedge mclk);
        chk({bkh, bkl, boh, rbs}, 4'b1001);
        $display("transition done");
        // Each fault source stops switching
        @(posedge mclk);
        for (int k = 0; k < 3; k++) begin
            {input_overvoltage_indication, uvl, enuv} <= 3'b100 >> k;
            repeat (10) @(posedge mclk);
            chk({bkh, bkl, boh, bol, rbs}, 0);
            bus_rd(4'h4);
            chk(st[5:3], k > 0 ? 3'b100 : 3'b010);
            {input_overvoltage_indication, uvl, enuv} <= 3'b000;
            repeat (200) @(posedge mclk);
            chk(rbs, 1);
        end
        $display("faults done");
        // Sync input: lock, fall back, relock after good periods
        ext_per <= 8'(`BBSS_PER0);
        bus_wr(4'h0, 32'h21);
        repeat (1200) @(posedge mclk);
        bus_rd(4'h4);
        chk({st[2], sync_oe_n, sync_out}, 3'b110);
        ext_per <= 8'h78;
        repeat (400) @(posedge mclk);
        bus_rd(4'h4);
        chk(st[2], 0);
        ext_per <= 8'(`BBSS_PER0);
        repeat (500) @(posedge mclk);
        bus_rd(4'h4);
        chk(st[2], 0);
        repeat (700) @(posedge mclk);
        bus_rd(4'h4);
        chk(st[2], 1);
        $display("sync done");
        // Upper control bits and unmapped places read zero
        bus_wr(4'h0, 32'hffff_ff21);
        bus_rd(4'h0);
        chk(st, 32'h21);
        bus_rd(4'h1);
        chk(st, 32'h0);
        $display("registers done");
        summarize;
    end
endmodule // bbss_sequencer_tb_top
`default_nettype wire
